// file: verilog/math_port_pkg.sv
// Package: constants and types for the stack math coprocessor port
`default_nettype none
package math_port_pkg;
  localparam int STACK_DEPTH_BYTES = 16;
  localparam int STACK_PTR_W = 4;
  localparam int DATA_W = 8;
  // Command byte fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 5;
  localparam int CMD_FIXED_BIT = 5;
  localparam int CMD_SINGLE_BIT = 6;
  localparam int CMD_SERVICE_REQUEST_OUT_BIT = 7;
  // Status byte fields
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_SIGN_BIT = 6;
  localparam int ST_ZERO_BIT = 5;
  localparam int ST_ERR_LSB = 1;
  localparam int ST_ERR_W = 4;
  localparam int ST_CARRY_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Error codes
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_DIV0 = 4'h8;
  localparam logic [3:0] ERR_NEG_ARG = 4'h4;
  localparam logic [3:0] ERR_ARG_BIG = 4'hc;
  localparam logic [3:0] ERR_UNDERFLOW = 4'h2;
  localparam logic [3:0] ERR_OVERFLOW = 4'h1;
  // Floating point word layout
  localparam int FP_SIGN_BIT = 31;
  localparam int FP_EXP_LSB = 24;
  localparam int FP_EXP_W = 7;
  localparam int FP_MANT_W = 24;
  localparam int FP_NORM_BIT = 23;
  // Execution time of the modelled commands minus one, in clock cycles
  localparam logic [7:0] EXEC_CYCLES = 8'h04;
  localparam int RESET_CYCLES = 5;
  // Opcodes carried out by the port's own datapath
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_CHS = 5'h14;
  localparam logic [4:0] OP_ADD = 5'h0c;
  localparam logic [4:0] OP_SUB = 5'h0d;
  localparam logic [4:0] OP_XCH = 5'h19;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC} exec_e;
endpackage
`default_nettype wire

// file: verilog/byte_buf_if.sv
// Interface: valid/ready byte channel between port and buffer
`default_nettype none
interface byte_buf_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: verilog/byte_skid_buf.sv
// Two-entry byte buffer with valid and ready on both sides
`default_nettype none
module byte_skid_buf #(
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic srst,
  byte_buf_if.snk in_ch,
  byte_buf_if.src out_ch
);
  logic [7:0] mem_q [DEPTH];
  logic [0:0] wr_ptr_q;
  logic [0:0] rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign in_ch.ready = (count_q != 2'(DEPTH));
  assign out_ch.valid = (count_q != 2'h0);
  assign out_ch.data = mem_q[rd_ptr_q];
  assign push = in_ch.valid && in_ch.ready;
  assign pop = out_ch.valid && out_ch.ready;

  // Storage, no reset needed on data
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_ch.data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + 2'(push) - 2'(pop);
    end
  end
endmodule // byte_skid_buf
`default_nettype wire

// file: verilog/math_coprocessor.sv
// Host port of the stack math coprocessor: stack, command, status, ready
// Overview of operation
// [RQ1] Fixed operands are two's complement, 16 or 32 bits wide.
// [RQ2] Fixed operand MSB is sign; negative held as two's complement.
// [RQ3] Float word: sign, 7-bit exponent, 24-bit fraction mantissa.
// [RQ4] Floats normalized with mantissa bit 23 set; zero is all zeros.
// [RQ5] Operand stack is eight 16-bit entries.
// [RQ6] Bytes written singly; read back in reverse order.
// [RQ7] Data write pushes byte on top; bottom byte is lost.
// [RQ8] Data read pops top byte, which rotates to bottom.
// [RQ9] Two-operand commands use top and second entry; one-operand only top.
// [RQ10] Write with select high enters a command; host keeps running.
// [RQ11] On completion end output goes low, busy clears, service request raised.
// [RQ12] End released by done_ack_n; service request cleared by service_ack_n.
// [RQ13] Command written while busy holds ready low until execution ends.
// [RQ14] Stack access while busy holds ready low until execution ends.
// [RQ15] Idle stack read holds ready low while top byte moves to latch.
// [RQ16] Idle stack write holds ready low until previous byte reached stack.
// [RQ17] Status read allowed any time; ready low while status is latched.
// [RQ18] Host holds bus controls stable while ready is low.
// [RQ19] Status shows busy, sign, zero and carry of last operation.
// [RQ20] Four-bit error code reports outcome of last operation.
// [RQ21] Status fields other than busy valid only when not busy.
// [RQ22] Select and strobes decode push, pop, command and status read.
// [RQ23] Command bits: 0-4 op, 5 fixed, 6 single, 7 service request.
// [RQ24] Reset aborts command, clears status, keeps stack and command.
// [RQ25] With done_ack_n held low, end output is one-clock pulse.
// [RQ26] Status: busy 7, sign 6, zero 5, error 4:1, carry 0.
`default_nettype none
module math_coprocessor
  import math_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic cmd_data_select,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic db_oe,
  input wire logic done_ack_n,
  input wire logic service_ack_n,
  output logic end_n_out,
  output logic end_n_oe,
  output logic service_request_out,
  output logic ready
);
  import math_port_pkg::*;

  // Two-flop synchronisers for all bus and acknowledge input pins; srst is used as is
  logic [5:0] pin_meta_q;
  logic [5:0] pin_q;
  logic [7:0] db_meta_q;
  logic [7:0] db_q;
  always_ff @(posedge clk_sys) begin
    pin_meta_q <= {cs_n, cmd_data_select, rd_n, wr_n, done_ack_n, service_ack_n};
    pin_q <= pin_meta_q;
    db_meta_q <= db_in;
    db_q <= db_meta_q;
  end
  logic cs_s, sel_s, rd_s, wr_s, done_ack_n_s, service_ack_n_s;
  assign {cs_s, sel_s, rd_s, wr_s, done_ack_n_s, service_ack_n_s} = pin_q;

  // [RQ22] transfer type decode
  logic acc_push, acc_pop, acc_cmd, acc_stat;
  assign acc_push = !cs_s && !sel_s && !wr_s && rd_s;
  assign acc_pop = !cs_s && !sel_s && !rd_s && wr_s;
  assign acc_cmd = !cs_s && sel_s && !wr_s && rd_s;
  assign acc_stat = !cs_s && sel_s && !rd_s && wr_s;

  // One access served per strobe assertion; done flag re-arms on release
  logic served_q;
  logic strobe_any;
  assign strobe_any = !cs_s && (!rd_s || !wr_s);

  exec_e state_q;
  logic busy;
  assign busy = (state_q == ST_EXEC);

  // Write buffer between the bus latch and the stack
  byte_buf_if wr_in ();
  byte_buf_if wr_out ();
  byte_skid_buf #(.DEPTH(2)) u_wbuf (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_ch(wr_in),
    .out_ch(wr_out)
  );

  // [RQ5] eight 16-bit entries kept as sixteen bytes
  logic [7:0] stack_q [STACK_DEPTH_BYTES];
  logic [7:0] cmd_q;
  logic [7:0] status_q;
  logic [7:0] latch_q;
  logic [7:0] exec_cnt_q;

  // Handshake accept terms
  logic take_push, take_pop, take_cmd, take_stat;
  // [RQ14] stack access stalls while busy
  // [RQ16] push waits for room in the buffer
  assign take_push = acc_push && !served_q && !busy && wr_in.ready;
  // [RQ15] pop also stalls while buffered bytes still drain
  assign take_pop = acc_pop && !served_q && !busy && !wr_out.valid;
  // [RQ13] command waits for execution end
  assign take_cmd = acc_cmd && !served_q && !busy;
  // [RQ17] status read honoured even while busy
  assign take_stat = acc_stat && !served_q;
  assign wr_in.valid = take_push;
  assign wr_in.data = db_q;
  // Stack drains buffer when nothing executes
  assign wr_out.ready = !busy;

  // Ready: low while a strobe is pending and not yet served.
  // The host must hold controls stable meanwhile.
  // [RQ18] relies on stable controls
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      served_q <= 1'b0;
    end else if (!strobe_any) begin
      served_q <= 1'b0;
    end else if (take_push || take_pop || take_cmd || take_stat) begin
      served_q <= 1'b1;
    end
  end
  assign ready = !strobe_any || served_q;

  // Execution engine: adds and subtracts in fixed format only, changes sign, exchanges
  logic [4:0] op;
  logic fixed_fmt, single_fmt;
  // [RQ23] command field split
  assign op = cmd_q[CMD_OP_LSB +: CMD_OP_W];
  assign fixed_fmt = cmd_q[CMD_FIXED_BIT];
  assign single_fmt = cmd_q[CMD_SINGLE_BIT];

  // [RQ9] operands from top and second entry
  logic [15:0] top_entry, second_entry;
  logic [31:0] top32, sec32;
  assign top_entry = {stack_q[0], stack_q[1]};
  assign second_entry = {stack_q[2], stack_q[3]};
  assign top32 = {stack_q[0], stack_q[1], stack_q[2], stack_q[3]};
  assign sec32 = {stack_q[4], stack_q[5], stack_q[6], stack_q[7]};

  // [RQ1] [RQ2] two's complement add/sub with carry and overflow
  logic [32:0] sum32;
  logic [16:0] sum16;
  logic [31:0] res32;
  logic [15:0] res16;
  logic carry_r, ovf_r;
  always_comb begin
    sum32 = 33'h000000000;
    sum16 = 17'h00000;
    res32 = top32;
    res16 = top_entry;
    carry_r = 1'b0;
    ovf_r = 1'b0;
    unique case (op)
      OP_ADD: begin
        sum32 = {1'b0, sec32} + {1'b0, top32};
        sum16 = {1'b0, second_entry} + {1'b0, top_entry};
        res32 = sum32[31:0];
        res16 = sum16[15:0];
        carry_r = single_fmt ? sum16[16] : sum32[32];
        ovf_r = single_fmt ? (second_entry[15] == top_entry[15]) && (res16[15] != top_entry[15])
                           : (sec32[31] == top32[31]) && (res32[31] != top32[31]);
      end
      OP_SUB: begin
        sum32 = {1'b0, sec32} - {1'b0, top32};
        sum16 = {1'b0, second_entry} - {1'b0, top_entry};
        res32 = sum32[31:0];
        res16 = sum16[15:0];
        carry_r = single_fmt ? sum16[16] : sum32[32];
        ovf_r = single_fmt ? (second_entry[15] != top_entry[15]) && (res16[15] != second_entry[15])
                           : (sec32[31] != top32[31]) && (res32[31] != sec32[31]);
      end
      OP_CHS: begin
        res32 = 32'h00000000 - top32;
        res16 = 16'h0000 - top_entry;
      end
      default: begin
        res32 = top32;
        res16 = top_entry;
      end
    endcase
  end

  // [RQ3] [RQ4] float sign flip keeps normalized zero as all zeros
  logic [31:0] fchs;
  assign fchs = (top32 == 32'h00000000) ? 32'h00000000 : {~top32[FP_SIGN_BIT], top32[30:0]};

  // Status from result
  logic [31:0] final32;
  always_comb begin
    final32 = top32;
    if (op == OP_XCH) begin
      final32 = sec32;
    end else if (!fixed_fmt && op == OP_CHS) begin
      final32 = fchs;
    end else if (fixed_fmt && !single_fmt) begin
      final32 = res32;
    end else if (fixed_fmt && single_fmt) begin
      final32 = {res16, stack_q[2], stack_q[3]};
    end
  end

  // Execution state and cycle counter
  logic finish;
  assign finish = busy && (exec_cnt_q == 8'h00);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      // [RQ24] abort and return to idle
      state_q <= ST_IDLE;
      exec_cnt_q <= 8'h00;
    end else if (take_cmd) begin
      // [RQ10] command accepted, host free to continue
      state_q <= ST_EXEC;
      exec_cnt_q <= EXEC_CYCLES;
    end else if (finish) begin
      state_q <= ST_IDLE;
    end else if (busy) begin
      exec_cnt_q <= exec_cnt_q - 8'h01;
    end
  end

  // Command register survives reset
  always_ff @(posedge clk_sys) begin
    if (take_cmd) begin
      cmd_q <= db_q;
    end
  end

  // Stack: push from buffer, pop rotates, result writes on finish
  always_ff @(posedge clk_sys) begin
    if (wr_out.valid && wr_out.ready) begin
      // [RQ7] push down, bottom byte lost
      // [RQ6] reverse order on read
      stack_q[0] <= wr_out.data;
      for (int i = 1; i < STACK_DEPTH_BYTES; i++) begin
        stack_q[i] <= stack_q[i-1];
      end
    end else if (take_pop) begin
      // [RQ8] top byte rotates to bottom
      stack_q[STACK_DEPTH_BYTES-1] <= stack_q[0];
      for (int i = 0; i < STACK_DEPTH_BYTES - 1; i++) begin
        stack_q[i] <= stack_q[i+1];
      end
    end else if (finish && !srst && op != OP_NOP) begin // Aborted command leaves the stack alone
      if (op == OP_XCH) begin
        {stack_q[0], stack_q[1], stack_q[2], stack_q[3]} <= sec32;
        {stack_q[4], stack_q[5], stack_q[6], stack_q[7]} <= top32;
      end else if (fixed_fmt && single_fmt) begin
        {stack_q[0], stack_q[1]} <= res16;
      end else begin
        {stack_q[0], stack_q[1], stack_q[2], stack_q[3]} <= final32;
      end
    end
  end

  // Status register
  logic [3:0] err_d;
  assign err_d = ovf_r ? ERR_OVERFLOW : ERR_NONE;
  logic res_neg, res_zero;
  assign res_neg = (fixed_fmt && single_fmt) ? final32[31] : final32[FP_SIGN_BIT];
  assign res_zero = (fixed_fmt && single_fmt) ? (final32[31:16] == 16'h0000) : (final32 == 32'h00000000);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_q <= STATUS_RESET;
    end else if (take_cmd) begin
      // [RQ19] busy set while executing
      status_q[ST_BUSY_BIT] <= 1'b1;
    end else if (finish) begin
      // [RQ26] status byte layout
      // [RQ20] error code of last op
      status_q[ST_BUSY_BIT] <= 1'b0;
      status_q[ST_SIGN_BIT] <= res_neg;
      status_q[ST_ZERO_BIT] <= res_zero;
      status_q[ST_ERR_LSB +: ST_ERR_W] <= err_d;
      status_q[ST_CARRY_BIT] <= carry_r;
    end
  end

  // Interface latch feeding the data bus
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      latch_q <= 8'h00;
    end else if (take_pop) begin
      latch_q <= stack_q[0];
    end else if (take_stat) begin
      // [RQ21] fields undefined while busy bit set
      latch_q <= status_q;
    end
  end
  assign db_out = latch_q;
  assign db_oe = !cs_s && !rd_s && served_q;

  // End and service request outputs
  logic end_q, service_request_out_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      end_q <= 1'b0;
      service_request_out_q <= 1'b0;
    end else begin
      // [RQ11] completion raises end, and service request only if command bit 7 is set
      // [RQ12] acks clear them; [RQ25] tied-low ack gives a pulse
      if (finish) begin
        end_q <= 1'b1;
      end else if (!done_ack_n_s) begin
        end_q <= 1'b0;
      end
      if (finish) begin
        service_request_out_q <= cmd_q[CMD_SERVICE_REQUEST_OUT_BIT];
      end else if (!service_ack_n_s || take_cmd) begin
        service_request_out_q <= 1'b0;
      end
    end
  end
  assign end_n_out = 1'b0;
  assign end_n_oe = end_q;
  assign service_request_out = service_request_out_q;
endmodule // math_coprocessor
`default_nettype wire

// file: sim/math_port_monitor.sv
// Checker of the coprocessor port pins, bound to the top module
`default_nettype none
module math_port_monitor (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic cmd_data_select,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] db_in,
  input wire logic [7:0] db_out,
  input wire logic db_oe,
  input wire logic done_ack_n,
  input wire logic service_ack_n,
  input wire logic end_n_out,
  input wire logic end_n_oe,
  input wire logic service_request_out,
  input wire logic ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain; pins pass a two-flop sync, hence the two-cycle lags
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  a_oe_read_only:
    assert property (db_oe |-> !$past(cs_n, 2) && !$past(rd_n, 2))
    else $error("bus driven without a read");
  a_ready_idle_high:
    assert property ((rd_n && wr_n) [*3] |-> ready)
    else $error("ready low with no strobe");
  a_status_ready:
    assert property ($fell(rd_n) && !cs_n && cmd_data_select && wr_n |-> ##2 !ready ##1 ready)
    else $error("status read ready timing wrong");
  a_end_pulse_one:
    assert property ($rose(end_n_oe) && !done_ack_n && !$past(done_ack_n) && !$past(done_ack_n, 2) |=> !end_n_oe)
    else $error("end pulse wider than one clock");
  a_end_ack_clears:
    assert property (end_n_oe && !done_ack_n |-> ##[1:4] !end_n_oe)
    else $error("end not released by acknowledge");
  a_service_request_out_ack_clears:
    assert property (service_request_out && !service_ack_n |-> ##[1:4] !service_request_out)
    else $error("service request not cleared");
  a_service_request_out_with_end:
    assert property ($rose(service_request_out) |-> end_n_oe)
    else $error("service request without end");
  a_reset_quiet:
    assert property (disable iff (1'b0) srst |=> !end_n_oe && !service_request_out)
    else $error("outputs active after reset");
  a_read_data_steady:
    assert property (db_oe && $past(db_oe) |-> $stable(db_out))
    else $error("read data changed while driven");
  a_end_drives_low:
    assert property (end_n_oe |-> !end_n_out)
    else $error("end line not driven low");
  // Stalls last at most the execution time plus the take cycle
  a_push_ready_back:
    assert property ($fell(wr_n) && !cs_n && !cmd_data_select && rd_n |-> ##2 !ready ##[1:8] ready)
    else $error("push ready not raised");
  a_pop_ready_back:
    assert property ($fell(rd_n) && !cs_n && !cmd_data_select && wr_n |-> ##2 !ready ##[1:8] ready)
    else $error("pop ready not raised");
  a_cmd_ready_back:
    assert property ($fell(wr_n) && !cs_n && cmd_data_select && rd_n |-> ##2 !ready ##[1:8] ready)
    else $error("command ready not raised");
endmodule // math_port_monitor
bind math_coprocessor math_port_monitor mon_u (.clk_sys, .srst, .cs_n, .cmd_data_select, .rd_n, .wr_n, .db_in,
  .db_out, .db_oe, .done_ack_n, .service_ack_n, .end_n_out, .end_n_oe, .service_request_out, .ready);
`default_nettype wire

// file: sim/host_model.sv
// Host processor model on the coprocessor's byte bus
`default_nettype none
module host_model (
  input wire logic clk_sys,
  input wire logic ready,
  input wire logic [7:0] db_out,
  input wire logic db_oe,
  output logic cs_n,
  output logic cmd_data_select,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] db_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle at time zero
  initial begin
    cs_n = 1'b1;
    cmd_data_select = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    db_in = 8'h00;
  end
  // select and strobe pick push, pop, command or status
  task automatic access(input logic sel, input logic is_rd, input logic [7:0] wd, output logic [7:0] rdat,
    output logic tmo);
    int n;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    cmd_data_select <= sel;
    rd_n <= !is_rd;
    wr_n <= is_rd;
    if (!is_rd) db_in <= wd;
    repeat (3) @(posedge clk_sys);
    // controls held until ready is sampled high
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    tmo = (n >= 400);
    // Undriven bus reads back inverted, so a missing enable shows up
    rdat = db_oe ? db_out : ~db_out;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    // Released bus shows no stale byte
    if (!is_rd) db_in <= ~wd;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule // host_model
`default_nettype wire

// file: sim/math_coprocessor_tb_top.sv
// Testbench: stack, command, status and handshake sequences
`default_nettype none
module math_coprocessor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import math_port_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic done_ack_n = 1'b1;
  logic service_ack_n = 1'b1;
  logic cs_n;
  logic cmd_data_select;
  logic rd_n;
  logic wr_n;
  logic [7:0] db_in;
  logic [7:0] db_out;
  logic db_oe;
  logic end_n_out;
  logic end_n_oe;
  logic service_request_out;
  logic ready;
  logic [7:0] rv;
  logic tmo;
  int failures = 0;
  int num_checks = 0;
  int pulses;
  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;
  math_coprocessor dut_u (.clk_sys, .srst, .cs_n, .cmd_data_select, .rd_n, .wr_n, .db_in, .db_out, .db_oe,
    .done_ack_n, .service_ack_n, .end_n_out, .end_n_oe, .service_request_out, .ready);
  host_model host_u (.clk_sys, .ready, .db_out, .db_oe, .cs_n, .cmd_data_select, .rd_n, .wr_n, .db_in);
  task automatic summarize();
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus cycle; a hang on ready shows as a mismatch
  task automatic xfer(input logic sel, input logic is_rd, input logic [7:0] wd);
    host_u.access(sel, is_rd, wd, rv, tmo);
    check({7'h00, tmo}, 8'h00);
  endtask
  task automatic wait_end();
    int n;
    n = 0;
    while (end_n_oe !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check({7'h00, end_n_oe}, 8'h01);
  endtask
  // Acknowledge pulse long enough to cross the input sync
  task automatic ack(input logic svc);
    @(posedge clk_sys);
    if (svc) service_ack_n <= 1'b0;
    else done_ack_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    service_ack_n <= 1'b1;
    done_ack_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    check({6'h00, service_request_out & svc, end_n_oe & !svc}, 8'h00);
  endtask
  // Two 16-bit operands, low byte first, then command, status and result
  task automatic arith(input logic [7:0] cmd, input logic [15:0] b, input logic [15:0] a, input logic [15:0] r,
    input logic [7:0] st);
    xfer(1'b0, 1'b0, b[7:0]);
    xfer(1'b0, 1'b0, b[15:8]);
    xfer(1'b0, 1'b0, a[7:0]);
    xfer(1'b0, 1'b0, a[15:8]);
    xfer(1'b1, 1'b0, cmd);
    wait_end();
    xfer(1'b1, 1'b1, 8'h00);
    check(rv, st);
    xfer(1'b0, 1'b1, 8'h00);
    check(rv, r[15:8]);
    xfer(1'b0, 1'b1, 8'h00);
    check(rv, r[7:0]);
    ack(1'b0);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    xfer(1'b1, 1'b1, 8'h00);
    check(rv, STATUS_RESET);
    // Seventeen pushes overflow the 16-byte stack by one
    for (int i = 0; i < 17; i++) xfer(1'b0, 1'b0, 8'(i + 16));
    for (int i = 16; i > 0; i--) begin
      xfer(1'b0, 1'b1, 8'h00);
      check(rv, 8'(i + 16));
    end
    xfer(1'b0, 1'b1, 8'h00);
    check(rv, 8'h20);
    // Zero result with carry, then negative result with borrow
    arith({3'b011, OP_ADD}, 16'h0001, 16'hffff, 16'h0000, 8'h21);
    arith({3'b011, OP_SUB}, 16'h0001, 16'h0002, 16'hffff, 8'h41);
    // Float sign change of +1.0, then of zero which must stay all zeros
    arith({3'b000, OP_CHS}, 16'h0000, 16'h0180, 16'h8180, 8'h40);
    arith({3'b000, OP_CHS}, 16'h0000, 16'h0000, 16'h0000, 8'h20);
    xfer(1'b1, 1'b0, {3'b100, OP_NOP});
    wait_end();
    check({7'h00, service_request_out}, 8'h01);
    ack(1'b1);
    ack(1'b0);
    // Acknowledge tied low: end must be a single clock wide
    @(posedge clk_sys);
    done_ack_n <= 1'b0;
    pulses = 0;
    fork
      xfer(1'b1, 1'b0, {3'b000, OP_NOP});
      repeat (30) begin
        @(posedge clk_sys);
        #1;
        if (end_n_oe === 1'b1) pulses++;
      end
    join
    check(8'(pulses), 8'h01);
    @(posedge clk_sys);
    done_ack_n <= 1'b1;
    // Reset in mid-command keeps the stack
    xfer(1'b0, 1'b0, 8'ha5);
    // Sign change would alter the top byte unless reset aborts it
    xfer(1'b1, 1'b0, {3'b111, OP_CHS});
    srst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    check({6'h00, end_n_oe, service_request_out}, 8'h00);
    xfer(1'b1, 1'b1, 8'h00);
    check(rv, STATUS_RESET);
    xfer(1'b0, 1'b1, 8'h00);
    check(rv, 8'ha5);
    summarize();
  end
  // Watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    summarize();
  end
endmodule // math_coprocessor_tb_top
`default_nettype wire
